// file: pkg/bcr_params.svh
// Register indices, field positions, reset values and bus widths of the buck configuration bank
`ifndef BCR_PARAMS_SVH
`define BCR_PARAMS_SVH
`define BCR_IDX_SECOND_CORE   8'h9D
`define BCR_IDX_FIRST_CORE    8'h9E
`define BCR_IDX_PROC_BUCK     8'h9F
`define BCR_IDX_STATUS        8'hA8
`define BCR_ADDR_W            12
`define BCR_REG_W             8
`define BCR_DATA_W            32
`define BCR_MODE_HI           7
`define BCR_MODE_LO           6
`define BCR_PD_OFF_BIT        5
`define BCR_TRACK_BIT         4
`define BCR_REF_OUT_BIT       3
`define BCR_SENSE_HI          2
`define BCR_SENSE_LO          0
`define BCR_CORE_WR_MASK      8'hE7
`define BCR_PROC_WR_MASK      8'hFF
`define BCR_RST_SECOND_CORE   8'h01
`define BCR_RST_FIRST_CORE    8'h01
`define BCR_RST_PROC_BUCK     8'h01
`define BCR_SENSE_NONE        3'h0
`define BCR_SENSE_OWN         3'h1
`endif

// file: pkg/bcr_pkg.sv
// Types shared by the buck configuration bank
package bcr_pkg;
	typedef enum logic [1:0] {
		BCR_MODE_BY_VOLTAGE_REG = 2'b00,
		BCR_MODE_FORCE_SLEEP    = 2'b01,
		BCR_MODE_FORCE_SYNC     = 2'b10,
		BCR_MODE_AUTO           = 2'b11
	} bcr_mode_e;
	typedef logic [2:0] bcr_sense_t;
endpackage : bcr_pkg

// file: logic/bcr_top.sv
// APB register bank and decoded controls for the core and processor buck configuration
//
// Design decision made here: the APB register port.
`include "bcr_params.svh"

// Overview of operation
// - Second core mode bits 7:6: 00 voltage regs, 01 sleep, 10 sync, 11 auto.
// - First core mode bits 7:6 decode the same four ways.
// - Processor mode: 00 voltage regs, 01 sleep, 10 sync, 11 auto.
// - Second core pull-down on when disabled and bit 5 low, never in dual phase.
// - First core and processor pull-down on when disabled and bit 5 low.
// - Second core sense bits mix own, core switch, peripheral switch; 000 invalid.
// - First core nonzero sense codes mix bitwise; 000 disables the sense mixer.
// - Bit 3 low routes reference port to comparator; high outputs half supply.
// - Processor sense bits mix sources bitwise; 000 is invalid.
module bcr_top
	import bcr_pkg::*;
#(
	parameter logic [7:0] RST_SECOND_CORE = `BCR_RST_SECOND_CORE,
	parameter logic [7:0] RST_FIRST_CORE  = `BCR_RST_FIRST_CORE,
	parameter logic [7:0] RST_PROC_BUCK   = `BCR_RST_PROC_BUCK
) (
	input  wire logic                      i_sys_clk,
	input  wire logic                      i_rst_n,
	input  wire logic                      i_psel,
	input  wire logic                      i_penable,
	input  wire logic                      i_pwrite,
	input  wire logic [`BCR_ADDR_W-1:0]    i_paddr,
	input  wire logic [`BCR_DATA_W-1:0]    i_pwdata,
	output logic                           o_pready,
	output logic                           o_pslverr,
	output logic [`BCR_DATA_W-1:0]         o_prdata,
	input  wire logic                      i_second_core_enabled,
	input  wire logic                      i_first_core_enabled,
	input  wire logic                      i_processor_buck_enabled,
	input  wire logic                      i_dual_phase_active,
	input  wire logic                      i_core_merge_flag,
	output bcr_mode_e                      o_second_core_mode_sel,
	output bcr_mode_e                      o_first_core_mode_sel,
	output bcr_mode_e                      o_processor_buck_mode_sel,
	output logic                           o_second_core_pulldown_on,
	output logic                           o_first_core_pulldown_on,
	output logic                           o_processor_buck_pulldown_on,
	output bcr_sense_t                     o_second_core_sense_mix,
	output bcr_sense_t                     o_first_core_sense_mix,
	output bcr_sense_t                     o_processor_buck_sense_mix,
	output logic                           o_first_core_diff_remote_sense,
	output logic                           o_first_core_mixer_off,
	output logic                           o_sense_invalid,
	output logic                           o_termination_track_active,
	output logic                           o_reference_out_enable,
	output logic                           o_comparator_input_assigned
);
	localparam int IDX_W = `BCR_ADDR_W - 2;

	logic                     rst_meta_q;
	logic                     rst_sync_n_q;
	logic [`BCR_REG_W-1:0]    second_core_q;
	logic [`BCR_REG_W-1:0]    first_core_q;
	logic [`BCR_REG_W-1:0]    proc_buck_q;
	logic [IDX_W-1:0]         idx;
	logic                     hit_second;
	logic                     hit_first;
	logic                     hit_proc;
	logic                     hit_status;
	logic                     mapped;
	logic                     setup;
	logic                     wr_take;
	logic [`BCR_REG_W-1:0]    status_d;
	logic [`BCR_REG_W-1:0]    rd_d;

	// Release of reset is synchronised; assertion stays asynchronous
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_q   <= 1'b0;
			rst_sync_n_q <= 1'b0;
		end else begin
			rst_meta_q   <= 1'b1;
			rst_sync_n_q <= rst_meta_q;
		end
	end

	// Word index; low address bits are ignored since every register is word aligned
	assign idx        = i_paddr[`BCR_ADDR_W-1:2];
	assign setup      = i_psel && !i_penable;
	assign wr_take    = i_psel && i_penable && o_pready && i_pwrite;

	always_comb begin
		hit_second = 1'b0;
		hit_first  = 1'b0;
		hit_proc   = 1'b0;
		hit_status = 1'b0;
		if (idx == IDX_W'(`BCR_IDX_SECOND_CORE)) begin
			hit_second = 1'b1;
		end else if (idx == IDX_W'(`BCR_IDX_FIRST_CORE)) begin
			hit_first = 1'b1;
		end else if (idx == IDX_W'(`BCR_IDX_PROC_BUCK)) begin
			hit_proc = 1'b1;
		end else if (idx == IDX_W'(`BCR_IDX_STATUS)) begin
			hit_status = 1'b1;
		end
	end
	assign mapped = hit_second || hit_first || hit_proc || hit_status;

	// Status word shows the decoded state, so software can see what the bucks really get
	assign status_d = {2'b00, o_termination_track_active, o_first_core_diff_remote_sense,
		o_first_core_mixer_off, o_sense_invalid, o_reference_out_enable, o_comparator_input_assigned};

	always_comb begin
		rd_d = '0;
		if (hit_second) begin
			rd_d = second_core_q;
		end else if (hit_first) begin
			rd_d = first_core_q;
		end else if (hit_proc) begin
			rd_d = proc_buck_q;
		end else if (hit_status) begin
			rd_d = status_d;
		end
	end

	// One wait-free access phase: pready rises for the cycle after setup
	always_ff @(posedge i_sys_clk or negedge rst_sync_n_q) begin
		if (!rst_sync_n_q) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata  <= '0;
		end else begin
			o_pready  <= setup;
			o_pslverr <= setup && (!mapped || (hit_status && i_pwrite));
			if (setup && !i_pwrite) begin
				o_prdata <= {{(`BCR_DATA_W-`BCR_REG_W){1'b0}}, rd_d};
			end
		end
	end

	// Writes land at the completing edge only; the status word is read-only
	always_ff @(posedge i_sys_clk or negedge rst_sync_n_q) begin
		if (!rst_sync_n_q) begin
			second_core_q <= RST_SECOND_CORE & `BCR_CORE_WR_MASK;
			first_core_q  <= RST_FIRST_CORE & `BCR_CORE_WR_MASK;
			proc_buck_q   <= RST_PROC_BUCK;
		end else if (wr_take) begin
			if (hit_second) begin
				second_core_q <= i_pwdata[`BCR_REG_W-1:0] & `BCR_CORE_WR_MASK;
			end
			if (hit_first) begin
				first_core_q <= i_pwdata[`BCR_REG_W-1:0] & `BCR_CORE_WR_MASK;
			end
			if (hit_proc) begin
				proc_buck_q <= i_pwdata[`BCR_REG_W-1:0] & `BCR_PROC_WR_MASK;
			end
		end
	end

	// Mode policy straight from the field; encoding matches the enum
	always_ff @(posedge i_sys_clk or negedge rst_sync_n_q) begin
		if (!rst_sync_n_q) begin
			o_second_core_mode_sel    <= BCR_MODE_BY_VOLTAGE_REG;
			o_first_core_mode_sel     <= BCR_MODE_BY_VOLTAGE_REG;
			o_processor_buck_mode_sel <= BCR_MODE_BY_VOLTAGE_REG;
		end else begin
			o_second_core_mode_sel    <= bcr_mode_e'(second_core_q[`BCR_MODE_HI:`BCR_MODE_LO]);
			o_first_core_mode_sel     <= bcr_mode_e'(first_core_q[`BCR_MODE_HI:`BCR_MODE_LO]);
			o_processor_buck_mode_sel <= bcr_mode_e'(proc_buck_q[`BCR_MODE_HI:`BCR_MODE_LO]);
		end
	end

	// Pull-downs only while the buck is off; dual phase overrides the second core
	always_ff @(posedge i_sys_clk or negedge rst_sync_n_q) begin
		if (!rst_sync_n_q) begin
			o_second_core_pulldown_on    <= 1'b0;
			o_first_core_pulldown_on     <= 1'b0;
			o_processor_buck_pulldown_on <= 1'b0;
		end else begin
			o_second_core_pulldown_on    <= !second_core_q[`BCR_PD_OFF_BIT] && !i_second_core_enabled
				&& !i_dual_phase_active;
			o_first_core_pulldown_on     <= !first_core_q[`BCR_PD_OFF_BIT] && !i_first_core_enabled;
			o_processor_buck_pulldown_on <= !proc_buck_q[`BCR_PD_OFF_BIT] && !i_processor_buck_enabled;
		end
	end

	// Sense mixing; an invalid code is passed on as is and flagged, not corrected
	always_ff @(posedge i_sys_clk or negedge rst_sync_n_q) begin
		if (!rst_sync_n_q) begin
			o_second_core_sense_mix        <= `BCR_SENSE_NONE;
			o_first_core_sense_mix         <= `BCR_SENSE_NONE;
			o_processor_buck_sense_mix     <= `BCR_SENSE_NONE;
			o_first_core_diff_remote_sense <= 1'b0;
			o_first_core_mixer_off         <= 1'b0;
			o_sense_invalid                <= 1'b0;
		end else begin
			o_second_core_sense_mix    <= second_core_q[`BCR_SENSE_HI:`BCR_SENSE_LO];
			o_processor_buck_sense_mix <= proc_buck_q[`BCR_SENSE_HI:`BCR_SENSE_LO];
			if (first_core_q[`BCR_SENSE_HI:`BCR_SENSE_LO] == `BCR_SENSE_NONE) begin
				o_first_core_mixer_off         <= 1'b1;
				o_first_core_diff_remote_sense <= i_core_merge_flag;
				o_first_core_sense_mix <= i_core_merge_flag ? `BCR_SENSE_NONE : `BCR_SENSE_OWN;
			end else begin
				o_first_core_mixer_off         <= 1'b0;
				o_first_core_diff_remote_sense <= 1'b0;
				o_first_core_sense_mix <= first_core_q[`BCR_SENSE_HI:`BCR_SENSE_LO];
			end
			o_sense_invalid <= (second_core_q[`BCR_SENSE_HI:`BCR_SENSE_LO] == `BCR_SENSE_NONE)
				|| (proc_buck_q[`BCR_SENSE_HI:`BCR_SENSE_LO] == `BCR_SENSE_NONE);
		end
	end

	// Tracking without the reference enabled stays in plain voltage mode
	always_ff @(posedge i_sys_clk or negedge rst_sync_n_q) begin
		if (!rst_sync_n_q) begin
			o_termination_track_active  <= 1'b0;
			o_reference_out_enable      <= 1'b0;
			o_comparator_input_assigned <= 1'b1;
		end else begin
			o_termination_track_active  <= proc_buck_q[`BCR_TRACK_BIT] && proc_buck_q[`BCR_REF_OUT_BIT];
			o_reference_out_enable      <= proc_buck_q[`BCR_REF_OUT_BIT];
			o_comparator_input_assigned <= !proc_buck_q[`BCR_REF_OUT_BIT];
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!rst_sync_n_q);

	AST_MODE_SECOND: assert property (wr_take && hit_second |-> ##2
		o_second_core_mode_sel == bcr_mode_e'($past(i_pwdata[`BCR_MODE_HI:`BCR_MODE_LO], 2)))
		else $error("Second core mode does not follow write");
	AST_MODE_FIRST: assert property (wr_take && hit_first |-> ##2
		o_first_core_mode_sel == bcr_mode_e'($past(i_pwdata[`BCR_MODE_HI:`BCR_MODE_LO], 2)))
		else $error("First core mode does not follow write");
	AST_MODE_PROC: assert property (wr_take && hit_proc |-> ##2
		o_processor_buck_mode_sel == bcr_mode_e'($past(i_pwdata[`BCR_MODE_HI:`BCR_MODE_LO], 2)))
		else $error("Processor mode does not follow write");
	AST_PD_DUAL: assert property (i_dual_phase_active |=> !o_second_core_pulldown_on)
		else $error("Second core pull-down active in dual phase");
	AST_PD_FIRST: assert property (!first_core_q[`BCR_PD_OFF_BIT] && !i_first_core_enabled
		|=> o_first_core_pulldown_on)
		else $error("First core pull-down missing while disabled");
	AST_PD_PROC_ON: assert property (i_processor_buck_enabled |=> !o_processor_buck_pulldown_on)
		else $error("Processor pull-down while enabled");
	AST_SENSE_SECOND: assert property ($changed(second_core_q) |=>
		o_second_core_sense_mix == $past(second_core_q[`BCR_SENSE_HI:`BCR_SENSE_LO]))
		else $error("Second core sense mix stale");
	AST_MERGE_DIFF: assert property (first_core_q[`BCR_SENSE_HI:`BCR_SENSE_LO] == `BCR_SENSE_NONE
		&& i_core_merge_flag |=> o_first_core_diff_remote_sense && o_first_core_mixer_off)
		else $error("Merged first core not in remote sensing");
	AST_FIRST_MIX: assert property (first_core_q[`BCR_SENSE_HI:`BCR_SENSE_LO] != `BCR_SENSE_NONE
		|=> !o_first_core_mixer_off && o_first_core_sense_mix != `BCR_SENSE_NONE)
		else $error("First core mixer wrongly off");
	AST_TRACK: assert property (proc_buck_q[`BCR_TRACK_BIT] && !proc_buck_q[`BCR_REF_OUT_BIT]
		|=> !o_termination_track_active)
		else $error("Tracking without reference output");
	AST_REF_ROUTE: assert property (proc_buck_q[`BCR_REF_OUT_BIT]
		|=> o_reference_out_enable && !o_comparator_input_assigned)
		else $error("Reference port assignment inconsistent");
	AST_SENSE_INVALID: assert property (proc_buck_q[`BCR_SENSE_HI:`BCR_SENSE_LO] == `BCR_SENSE_NONE
		|=> o_sense_invalid)
		else $error("Invalid processor sense code not flagged");
	AST_RESERVED: assert property (##1 second_core_q[`BCR_TRACK_BIT:`BCR_REF_OUT_BIT] == 2'b00
		&& first_core_q[`BCR_TRACK_BIT:`BCR_REF_OUT_BIT] == 2'b00)
		else $error("Reserved core bits set");
	AST_PREADY: assert property (setup |=> o_pready ##1 !o_pready)
		else $error("Ready not a single access cycle");

	AST_WRITE_SECOND: assert property (wr_take && hit_second |=>
		second_core_q == ($past(i_pwdata[`BCR_REG_W-1:0]) & `BCR_CORE_WR_MASK))
		else $error("Second core register write lost");
	AST_WRITE_FIRST: assert property (wr_take && hit_first |=>
		first_core_q == ($past(i_pwdata[`BCR_REG_W-1:0]) & `BCR_CORE_WR_MASK))
		else $error("First core register write lost");
	AST_WRITE_PROC: assert property (wr_take && hit_proc |=>
		proc_buck_q == $past(i_pwdata[`BCR_REG_W-1:0]))
		else $error("Processor register write lost");
	AST_HOLD_REGS: assert property (!(wr_take && (hit_second || hit_first || hit_proc)) |=>
		$stable(second_core_q) && $stable(first_core_q) && $stable(proc_buck_q))
		else $error("Register changed without a write");

	AST_READ_SECOND: assert property (setup && !i_pwrite && hit_second |=>
		o_prdata == {{(`BCR_DATA_W-`BCR_REG_W){1'b0}}, $past(second_core_q)})
		else $error("Second core read data wrong");
	AST_READ_FIRST: assert property (setup && !i_pwrite && hit_first |=>
		o_prdata == {{(`BCR_DATA_W-`BCR_REG_W){1'b0}}, $past(first_core_q)})
		else $error("First core read data wrong");
	AST_READ_PROC: assert property (setup && !i_pwrite && hit_proc |=>
		o_prdata == {{(`BCR_DATA_W-`BCR_REG_W){1'b0}}, $past(proc_buck_q)})
		else $error("Processor read data wrong");
	AST_READ_UNMAPPED: assert property (setup && !i_pwrite && !mapped |=>
		o_pslverr && o_prdata == '0)
		else $error("Unmapped read not refused");
	AST_SLVERR_RO: assert property (setup && hit_status && i_pwrite |=>
		o_pslverr)
		else $error("Status write not refused");
	AST_SLVERR_OK: assert property (setup && mapped && !(hit_status && i_pwrite) |=>
		!o_pslverr)
		else $error("Legal access refused");

	AST_PD_SECOND: assert property (!second_core_q[`BCR_PD_OFF_BIT] && !i_second_core_enabled
		&& !i_dual_phase_active |=> o_second_core_pulldown_on)
		else $error("Second core pull-down missing while disabled");
	AST_PD_SECOND_ON: assert property (i_second_core_enabled || second_core_q[`BCR_PD_OFF_BIT]
		|=> !o_second_core_pulldown_on)
		else $error("Second core pull-down wrongly applied");
	AST_PD_FIRST_ON: assert property (i_first_core_enabled || first_core_q[`BCR_PD_OFF_BIT]
		|=> !o_first_core_pulldown_on)
		else $error("First core pull-down wrongly applied");
	AST_PD_PROC: assert property (!proc_buck_q[`BCR_PD_OFF_BIT] && !i_processor_buck_enabled
		|=> o_processor_buck_pulldown_on)
		else $error("Processor pull-down missing while disabled");
	AST_PD_PROC_OFF: assert property (proc_buck_q[`BCR_PD_OFF_BIT]
		|=> !o_processor_buck_pulldown_on)
		else $error("Processor pull-down despite bit set");

	AST_SENSE_PROC: assert property ($changed(proc_buck_q) |=>
		o_processor_buck_sense_mix == $past(proc_buck_q[`BCR_SENSE_HI:`BCR_SENSE_LO]))
		else $error("Processor sense mix stale");
	AST_FIRST_OWN: assert property (first_core_q[`BCR_SENSE_HI:`BCR_SENSE_LO] == `BCR_SENSE_NONE
		&& !i_core_merge_flag |=> o_first_core_sense_mix == `BCR_SENSE_OWN
		&& !o_first_core_diff_remote_sense)
		else $error("Unmerged first core not on own output");
	AST_FIRST_COPY: assert property (first_core_q[`BCR_SENSE_HI:`BCR_SENSE_LO] != `BCR_SENSE_NONE
		|=> o_first_core_sense_mix == $past(first_core_q[`BCR_SENSE_HI:`BCR_SENSE_LO])
		&& !o_first_core_diff_remote_sense)
		else $error("First core sense mix not the field");
	AST_SECOND_INVALID: assert property (second_core_q[`BCR_SENSE_HI:`BCR_SENSE_LO] == `BCR_SENSE_NONE
		|=> o_sense_invalid)
		else $error("Invalid second core sense code not flagged");
	AST_SENSE_VALID: assert property (second_core_q[`BCR_SENSE_HI:`BCR_SENSE_LO] != `BCR_SENSE_NONE
		&& proc_buck_q[`BCR_SENSE_HI:`BCR_SENSE_LO] != `BCR_SENSE_NONE |=> !o_sense_invalid)
		else $error("Valid sense codes flagged invalid");

	AST_TRACK_ON: assert property (proc_buck_q[`BCR_TRACK_BIT] && proc_buck_q[`BCR_REF_OUT_BIT]
		|=> o_termination_track_active)
		else $error("Tracking not active with both bits set");
	AST_CMP_ROUTE: assert property (!proc_buck_q[`BCR_REF_OUT_BIT]
		|=> !o_reference_out_enable && o_comparator_input_assigned)
		else $error("Reference port not on comparator");

	COV_WRITE_PROC: cover property (wr_take && hit_proc);
	COV_MERGE: cover property (o_first_core_diff_remote_sense);
	COV_TRACK: cover property (o_termination_track_active);
	COV_BAD_ADDR: cover property (o_pslverr && o_pready);
	COV_DUAL: cover property (i_dual_phase_active && !i_second_core_enabled);
endmodule : bcr_top

// file: bench/bcr_apb_host.sv
// Host-side APB master model for the buck configuration bank
module bcr_apb_host (
	input  wire logic        i_clk,
	input  wire logic        i_pready,
	input  wire logic        i_pslverr,
	input  wire logic [31:0] i_prdata,
	output logic             o_psel,
	output logic             o_penable,
	output logic             o_pwrite,
	output logic [11:0]      o_paddr,
	output logic [31:0]      o_pwdata,
	output logic             o_hung
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 12'h000;
		o_pwdata = 32'h0000_0000;
		o_hung = 1'b0;
	end
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge i_clk);
		o_psel <= 1'b1;
		o_pwrite <= w;
		o_paddr <= a;
		o_pwdata <= d;
		@(posedge i_clk);
		o_penable <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
		end while (i_pready !== 1'b1 && n < 20);
		o_hung = (i_pready !== 1'b1);
		r = i_prdata;
		e = i_pslverr;
		o_psel <= 1'b0;
		o_penable <= 1'b0;
		// Released lines toggle so a slave cannot lean on stale address or data
		o_paddr <= ~a;
		o_pwdata <= ~d;
	endtask : xfer
endmodule : bcr_apb_host

// file: bench/buck_config_registers_bench.sv
// Self-checking bench for the buck configuration bank
`include "bcr_params.svh"
module buck_config_registers_bench
	import bcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] A2 = {2'b00, `BCR_IDX_SECOND_CORE, 2'b00};
	localparam logic [11:0] A1 = {2'b00, `BCR_IDX_FIRST_CORE, 2'b00};
	localparam logic [11:0] AP = {2'b00, `BCR_IDX_PROC_BUCK, 2'b00};
	localparam logic [11:0] AS = {2'b00, `BCR_IDX_STATUS, 2'b00};
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, hung;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        en2 = 1'b0, en1 = 1'b0, enp = 1'b0, dual = 1'b0, merge = 1'b0;
	bcr_mode_e   m2, m1, mp;
	bcr_sense_t  s2, s1, sp;
	logic        pd2, pd1, pdp, diff, moff, inv, trk, rout, cmp;
	int          failures = 0;
	int          num_checks = 0;
	always #5 clk = ~clk;
	bcr_apb_host host (.i_clk(clk), .i_pready(pready), .i_pslverr(pslverr), .i_prdata(prdata),
		.o_psel(psel), .o_penable(penable), .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .o_hung(hung));
	bcr_top DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
		.i_second_core_enabled(en2), .i_first_core_enabled(en1), .i_processor_buck_enabled(enp),
		.i_dual_phase_active(dual), .i_core_merge_flag(merge),
		.o_second_core_mode_sel(m2), .o_first_core_mode_sel(m1), .o_processor_buck_mode_sel(mp),
		.o_second_core_pulldown_on(pd2), .o_first_core_pulldown_on(pd1), .o_processor_buck_pulldown_on(pdp),
		.o_second_core_sense_mix(s2), .o_first_core_sense_mix(s1), .o_processor_buck_sense_mix(sp),
		.o_first_core_diff_remote_sense(diff), .o_first_core_mixer_off(moff), .o_sense_invalid(inv),
		.o_termination_track_active(trk), .o_reference_out_enable(rout), .o_comparator_input_assigned(cmp));
	task automatic test_done;
		if (failures == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ee,
			input logic [31:0] er, input string nm);
		logic [31:0] r;
		logic        e;
		host.xfer(w, a, d, r, e);
		if (hung !== 1'b0) begin
			failures++;
			test_done;
		end
		chk({nm, "_err"}, {31'h0, e}, {31'h0, ee});
		if (!w) chk(nm, r, er);
	endtask : acc
	// Decoded outputs trail the register by one edge, so two edges cover it
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	task automatic setin(input logic [4:0] v);
		@(posedge clk);
		{en2, en1, enp, dual, merge} <= v;
		settle;
	endtask : setin
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("cmp_rst", cmp, 1);
		acc(0, A2, 0, 0, 32'h0000_0001, "rst2");
		for (int m = 0; m < 4; m++) begin
			acc(1, A2, {24'h0, m[1:0], 6'h21}, 0, 0, "w2");
			acc(1, A1, {24'h0, m[1:0], 6'h21}, 0, 0, "w1");
			acc(1, AP, {24'h0, m[1:0], 6'h21}, 0, 0, "wp");
			settle;
			chk("mode2", m2, m);
			chk("mode1", m1, m);
			chk("modep", mp, m);
		end
		acc(1, A2, 32'hFFFF_FFFF, 0, 0, "w2");
		acc(0, A2, 0, 0, 32'h0000_00E7, "rsv2");
		acc(1, A1, 32'hFFFF_FFFF, 0, 0, "w1");
		acc(0, A1, 0, 0, 32'h0000_00E7, "rsv1");
		acc(1, A2, 32'h0000_0002, 0, 0, "w2");
		acc(1, A1, 32'h0000_0004, 0, 0, "w1");
		acc(1, AP, 32'h0000_0001, 0, 0, "wp");
		settle;
		chk("pd2", pd2, 1);
		chk("pd1", pd1, 1);
		chk("pdp", pdp, 1);
		chk("s2", s2, 2);
		chk("s1", s1, 4);
		chk("moff", moff, 0);
		chk("inv", inv, 0);
		setin(5'b00010);
		chk("pd2_dual", pd2, 0);
		chk("pd1_dual", pd1, 1);
		setin(5'b11100);
		chk("pd2_on", pd2, 0);
		chk("pd1_on", pd1, 0);
		chk("pdp_on", pdp, 0);
		setin(5'b00000);
		acc(1, AP, 32'h0000_0021, 0, 0, "wp");
		acc(1, A2, 32'h0000_0000, 0, 0, "w2");
		acc(1, A1, 32'h0000_0000, 0, 0, "w1");
		settle;
		chk("pdp_off", pdp, 0);
		chk("inv2", inv, 1);
		chk("s2_0", s2, 0);
		chk("s1_own", s1, 1);
		chk("diff0", diff, 0);
		chk("moff1", moff, 1);
		setin(5'b00001);
		chk("s1_merge", s1, 0);
		chk("diff1", diff, 1);
		acc(1, A2, 32'h0000_0001, 0, 0, "w2");
		acc(1, AP, 32'h0000_0011, 0, 0, "wp");
		settle;
		chk("inv_ok", inv, 0);
		chk("trk_half", trk, 0);
		chk("rout0", rout, 0);
		chk("cmp1", cmp, 1);
		acc(1, AP, 32'h0000_0018, 0, 0, "wp");
		settle;
		chk("trk1", trk, 1);
		chk("rout1", rout, 1);
		chk("cmp0", cmp, 0);
		chk("invp", inv, 1);
		chk("sp0", sp, 0);
		acc(0, AP, 0, 0, 32'h0000_0018, "rdp");
		acc(1, A2, 32'h0000_0000, 0, 0, "w2");
		settle;
		acc(0, AS, 0, 0, 32'h0000_003E, "status");
		acc(0, 12'h280, 0, 1, 0, "unmapped");
		acc(1, AS, 32'h0000_00FF, 1, 0, "ro");
		acc(0, AS, 0, 0, 32'h0000_003E, "status2");
		test_done;
	end
endmodule : buck_config_registers_bench
